// [bench/eep_asserts.sv]
// port checks for the eeprom controller
`timescale 1ns/1ps
`default_nettype none
module eep_asserts
  import eep_pkg::*;
(
  input wire logic MCLK, // clock
  input wire logic RST_N, // reset
  input wire logic [11:0] AVS_ADDRESS, // address
  input wire logic AVS_READ, // read
  input wire logic AVS_WRITE, // write
  input wire logic [31:0] AVS_WRITEDATA, // write data
  input wire logic [3:0] AVS_BYTEENABLE, // lanes
  input wire logic [31:0] AVS_READDATA, // read data
  input wire logic AVS_WAITREQUEST, // stall
  input wire logic PUMP_ON, // pump
  input wire logic PUMP_CLK_RC, // rc clock
  input wire logic TEST_MODE, // test
  input wire logic UPPER_UNLOCKED, // unlock
  input wire logic READOUT_LOCKED // lock
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // reset leaves everything off but the lock
  a_reset_clear: assert property ($rose(RST_N) |-> !PUMP_ON && !TEST_MODE && READOUT_LOCKED)
    else $error("outputs not cleared by reset");
  a_test_refused: assert property (READOUT_LOCKED |-> !TEST_MODE)
    else $error("test mode granted while locked");
  // latches move only at the reset edge and as the loader runs after it
  a_latch_hold: assert property ($changed({UPPER_UNLOCKED, READOUT_LOCKED})
    |-> !$past(RST_N) || !$past(RST_N, 2))
    else $error("option latch changed without reset");
  a_write_answer: assert property ($rose(AVS_WRITE) && AVS_ADDRESS == CTRL_ADDR
    |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("control write answer late");
  a_read_answer: assert property ($rose(AVS_READ) && AVS_ADDRESS[11:10] == 2'b01
    |-> AVS_WAITREQUEST [*2] ##1 !AVS_WAITREQUEST)
    else $error("array read answer not at second edge");
  // pump starts only from a taken control write with latch and pump set
  a_pump_rise: assert property ($rose(PUMP_ON) |-> $past(AVS_WRITE && !AVS_WAITREQUEST
    && AVS_ADDRESS == CTRL_ADDR && AVS_WRITEDATA[PGM_BIT] && AVS_WRITEDATA[LAT_BIT]))
    else $error("pump started without control write");
  a_pump_fall: assert property ($fell(PUMP_ON) |-> $past(AVS_WRITE && !AVS_WAITREQUEST
    && (AVS_ADDRESS == CTRL_ADDR && !AVS_WRITEDATA[LAT_BIT]
    || AVS_ADDRESS == MODE_ADDR && AVS_WRITEDATA[STOP_BIT])))
    else $error("pump stopped without latch clear or stop");
  a_rc_follow: assert property (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
    && AVS_ADDRESS == MODE_ADDR |=> PUMP_CLK_RC == $past(AVS_WRITEDATA[RC_BIT]))
    else $error("rc select not taken");
endmodule : eep_asserts
bind eep_ctrl eep_asserts u_asserts (.MCLK(MCLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .PUMP_ON(PUMP_ON), .PUMP_CLK_RC(PUMP_CLK_RC),
  .TEST_MODE(TEST_MODE), .UPPER_UNLOCKED(UPPER_UNLOCKED), .READOUT_LOCKED(READOUT_LOCKED));
`default_nettype wire

// [bench/eep_cpu.sv]
// bus master model standing in for the cpu core
`timescale 1ns/1ps
`default_nettype none
module eep_cpu (
  input wire logic MCLK, // clock
  input wire logic AVS_WAITREQUEST, // stall
  input wire logic [31:0] AVS_READDATA, // read data
  output var logic [11:0] AVS_ADDRESS, // address
  output var logic AVS_READ, // read
  output var logic AVS_WRITE, // write
  output var logic [31:0] AVS_WRITEDATA // write data
);
  // idle bus at time zero
  initial begin
    AVS_ADDRESS = 12'h000;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0000_0000;
  end
  // one transfer: raised after an edge, held until waitrequest seen low
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h00_0000, d};
    AVS_WRITE <= w;
    AVS_READ <= !w;
    // waitrequest and read data are taken at the rising edge, released right after it
    do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA[7:0];
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    AVS_WRITEDATA <= ~AVS_WRITEDATA; // released data never repeats the last value
    @(negedge MCLK);
  endtask : acc
endmodule : eep_cpu
`default_nettype wire

// [bench/eeprom_byte_program_erase_ctrl_tb.sv]
// self-checking bench for the eeprom controller
`timescale 1ns/1ps
`default_nettype none
module eeprom_byte_program_erase_ctrl_tb
  import eep_pkg::*;
;
  typedef struct {logic [7:0] n; logic [7:0] d; logic [7:0] x;} eep_row_t;
  eep_row_t rows [5] = '{'{8'h01, 8'hA5, 8'hA5}, '{8'h02, 8'h00, 8'h00},
    '{8'h20, 8'h3C, 8'h3C}, '{8'h1F, 8'h00, 8'h00}, '{8'hFF, 8'h5A, 8'h5A}};
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic [3:0] be = 4'hF;
  logic [11:0] addr;
  logic rd_en, wr_en, waitreq, pump_on, pump_rc, test_mode, unlocked, locked;
  logic [31:0] wdata, rdata;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  eep_ctrl uut (.MCLK(MCLK), .RST_N(RST_N), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
    .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .PUMP_ON(pump_on), .PUMP_CLK_RC(pump_rc),
    .TEST_MODE(test_mode), .UPPER_UNLOCKED(unlocked), .READOUT_LOCKED(locked));
  eep_cpu m (.MCLK(MCLK), .AVS_WAITREQUEST(waitreq), .AVS_READDATA(rdata),
    .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata));
  // 100 ns clock
  initial begin
    forever #50 MCLK = ~MCLK;
  end
  // hang guard, far above the under one thousand cycles needed
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t data %h expected %h", $time, got, exp);
    end
  endtask : chk8
  function automatic logic [11:0] arr(input logic [7:0] n);
    return 12'h400 + {2'b00, n, 2'b00};
  endfunction : arr
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    m.acc(1'b1, a, d, q);
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [7:0] x);
    logic [7:0] q;
    m.acc(1'b0, a, 8'h00, q);
    chk8(q, x);
  endtask : rchk
  // reset seen low at the next edge, checked, then the option loader gets its edge
  task automatic rst;
    @(posedge MCLK) RST_N <= 1'b0;
    @(posedge MCLK) RST_N <= 1'b1;
    @(negedge MCLK);
    chk1(pump_on, 1'b0);
    chk1(locked, 1'b1);
    repeat (2) @(posedge MCLK);
    @(negedge MCLK);
  endtask : rst
  // bootstrap wipe; the next write stalls until it ends
  task automatic boot;
    wr(MODE_ADDR, 8'h10);
    wr(MODE_ADDR, 8'h00);
  endtask : boot
  // software sequence, run only from the bench, never fetching from the array
  task automatic op(input logic [7:0] n, input logic [7:0] d, input logic era);
    wr(CTRL_ADDR, {5'h00, era, 2'b10});
    wr(arr(n), d);
    wr(CTRL_ADDR, {5'h00, era, 2'b11});
    chk1(pump_on, 1'b1);
    wr(CTRL_ADDR, 8'h00);
    chk1(pump_on, 1'b0);
  endtask : op
  initial begin
    rst();
    boot();
    rst();
    chk1(unlocked, 1'b1);
    chk1(locked, 1'b0);
    foreach (rows[i]) begin
      op(rows[i].n, 8'h00, 1'b1);
      op(rows[i].n, rows[i].d, 1'b0);
      rchk(arr(rows[i].n), rows[i].x);
    end
    wr(CTRL_ADDR, 8'h05);
    rchk(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h06);
    rchk(arr(8'h01), 8'hFF);
    wr(CTRL_ADDR, 8'h07);
    chk1(pump_on, 1'b0);
    wr(arr(8'h01), 8'h00);
    wr(arr(8'h02), 8'h00);
    wr(CTRL_ADDR, 8'h03);
    wr(CTRL_ADDR, 8'h00);
    rchk(arr(8'h01), 8'hFF);
    rchk(arr(8'h02), 8'h00);
    wr(arr(8'h01), 8'h00);
    rchk(arr(8'h01), 8'hFF);
    rchk(12'h030, 8'h00);
    @(posedge MCLK) be <= 4'h0;
    wr(CTRL_ADDR, 8'h02);
    @(posedge MCLK) be <= 4'hF;
    rchk(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h02);
    wr(arr(8'h03), 8'h00);
    wr(CTRL_ADDR, 8'h03);
    wr(MODE_ADDR, 8'h06);
    chk1(pump_on, 1'b1);
    chk1(pump_rc, 1'b1);
    wr(MODE_ADDR, 8'h01);
    chk1(pump_on, 1'b0);
    rchk(CTRL_ADDR, 8'h00);
    wr(MODE_ADDR, 8'h08);
    chk1(test_mode, 1'b1);
    op(8'h00, 8'hFD, 1'b0);
    rchk(arr(8'h00), 8'hFD);
    chk1(unlocked, 1'b1);
    rst();
    chk1(unlocked, 1'b0);
    op(8'h20, 8'h00, 1'b0);
    rchk(arr(8'h20), 8'h3C);
    op(8'h1F, 8'h00, 1'b1);
    rchk(arr(8'h1F), 8'hFF);
    op(8'h00, 8'hFC, 1'b0);
    chk1(locked, 1'b0);
    rst();
    chk1(locked, 1'b1);
    wr(MODE_ADDR, 8'h08);
    chk1(test_mode, 1'b0);
    boot();
    rchk(arr(8'h20), 8'hFF);
    chk1(locked, 1'b1);
    rst();
    chk1(locked, 1'b0);
    end_sim();
  end
endmodule : eeprom_byte_program_erase_ctrl_tb
`default_nettype wire

// [core/eep_arr_if.sv]
// interface: array port between controller and storage
`timescale 1ns/1ps
`default_nettype none
interface eep_arr_if;
  logic we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : eep_arr_if
`default_nettype wire

// [core/eep_array.sv]
// storage array of 256 bytes with registered read data
`timescale 1ns/1ps
`default_nettype none
module eep_array
  import eep_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input wire logic MCLK, // system clock
  eep_arr_if.mem arr // array port
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rd;
  // nonvolatile contents: no reset so power-up state survives register reset
  always_ff @(posedge MCLK) begin
    if (arr.we) begin
      mem[arr.waddr] <= arr.wdata;
    end
    rd <= mem[arr.raddr];
  end
  assign arr.rdata = rd;
endmodule : eep_array
`default_nettype wire

// [core/eep_ctrl.sv]
// EEPROM byte erase/program controller with Avalon-MM slave
// Overview of operation
// - read mode clears erase and pump bits
// - pump off whenever pump bit clear
// - array reads return FF while latched
// - array accesses fail during operation
// - erased reads FF, programmed reads 00
// - erase ignores written data value
// - other addresses ignored once latched
// - upper 224 bytes protected unless unlocked
// - reset copies option byte into latches
// - unlock takes effect only after reset
// - clearing unlock needs latch enable set
// - locked readout refuses test mode entry
// - bootstrap entry unlocks and wipes array
// - readout lock change waits for reset
// - stop forces read mode, pump off
// - wait mode leaves operation running
// - pump clock may use rc oscillator
// - erase select frozen after address latch
// - pump needs data first, clears with latch
// - stop and resets clear latch enable
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module eep_ctrl
  import eep_pkg::*;
(
  input wire logic MCLK, // 10 MHz clock
  input wire logic RST_N, // synchronous reset, active low
  input wire logic [11:0] AVS_ADDRESS, // byte address
  input wire logic AVS_READ, // read request
  input wire logic AVS_WRITE, // write request
  input wire logic [31:0] AVS_WRITEDATA, // write data
  input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
  output logic [31:0] AVS_READDATA, // read data
  output logic AVS_WAITREQUEST, // stall
  output logic PUMP_ON, // charge pump running
  output logic PUMP_CLK_RC, // pump clocked from rc oscillator
  output logic TEST_MODE, // test mode granted
  output logic UPPER_UNLOCKED, // latched unlock
  output logic READOUT_LOCKED // latched security active
);
  eep_arr_if arr ();
  eep_array #(.DEPTH(256)) u_array (.MCLK(MCLK), .arr(arr));

  eep_state_t state, next_state;
  logic prog_latch_enable, next_prog_latch_enable;
  logic erase_select, next_erase_select;
  logic pump_enable, next_pump_enable;
  logic addr_latched, next_addr_latched;
  logic [7:0] lat_addr, next_lat_addr;
  logic [7:0] lat_data, next_lat_data;
  logic upper_region_unlock, next_upper_region_unlock;
  logic readout_lock, next_readout_lock;
  logic rc_osc_select, next_rc_osc_select;
  logic wait_mode, next_wait_mode;
  logic test_mode, next_test_mode;
  logic [7:0] wipe_ptr, next_wipe_ptr;
  logic ack, next_ack;
  logic rd_pending, next_rd_pending;
  logic [31:0] rdata, next_rdata;
  logic rd_blank, next_rd_blank;

  // decode helpers
  function automatic logic is_array(input logic [11:0] a);
    return a[11:10] == ARRAY_IDX[9:8] && a[1:0] == 2'b00;
  endfunction : is_array
  function automatic logic protected_offs(input logic [7:0] off, input logic unlock);
    return !unlock && off >= UNPROT_LIMIT;
  endfunction : protected_offs

  logic req, take, wr_ctrl, wr_mode, wr_arr, rd_arr, lane0;
  logic [7:0] wbyte, off;
  logic store;
  logic [7:0] store_val;
  // a request opens the answer; a write lands only at the edge where waitrequest is low
  assign req = (AVS_READ || AVS_WRITE) && !ack && state == ST_RUN;
  assign take = AVS_WRITE && ack && state == ST_RUN;
  assign lane0 = AVS_BYTEENABLE[0];
  assign wbyte = AVS_WRITEDATA[7:0];
  assign off = AVS_ADDRESS[9:2];
  assign wr_ctrl = take && lane0 && AVS_ADDRESS == CTRL_ADDR;
  assign wr_mode = take && lane0 && AVS_ADDRESS == MODE_ADDR;
  assign wr_arr = take && lane0 && is_array(AVS_ADDRESS);
  assign rd_arr = req && AVS_READ && is_array(AVS_ADDRESS);

  // control bits, address latch, options and mode next values
  always_comb begin
    next_prog_latch_enable = prog_latch_enable;
    next_erase_select = erase_select;
    next_pump_enable = pump_enable;
    next_addr_latched = addr_latched;
    next_lat_addr = lat_addr;
    next_lat_data = lat_data;
    next_upper_region_unlock = upper_region_unlock;
    next_readout_lock = readout_lock;
    next_rc_osc_select = rc_osc_select;
    next_wait_mode = wait_mode;
    next_test_mode = test_mode;
    next_state = state;
    next_wipe_ptr = wipe_ptr;
    store = 1'b0;
    store_val = lat_data;
    unique case (state)
      ST_LOAD: begin
        // option byte read was issued last cycle; latch it now
        next_upper_region_unlock = arr.rdata[PROT_BIT];
        next_readout_lock = !arr.rdata[SEC_BIT];
        next_state = ST_RUN;
      end
      ST_WIPE: begin
        // bootstrap entry wipes every byte, option byte ends erased
        store = 1'b1;
        store_val = ERASED;
        next_wipe_ptr = 8'(wipe_ptr + 8'h01);
        if (wipe_ptr == 8'hFF) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wr_ctrl) begin
          next_prog_latch_enable = wbyte[LAT_BIT];
          if (!addr_latched) begin
            next_erase_select = wbyte[ERA_BIT];
          end
          if (wbyte[PGM_BIT] && addr_latched) begin
            next_pump_enable = 1'b1;
          end
        end
        if (wr_arr && prog_latch_enable && !pump_enable && !addr_latched) begin
          // first write picks the byte; later writes elsewhere dropped
          next_addr_latched = 1'b1;
          next_lat_addr = off;
          next_lat_data = erase_select ? ERASED : wbyte;
        end else if (wr_arr && prog_latch_enable && !pump_enable && off == lat_addr) begin
          next_lat_data = erase_select ? ERASED : wbyte;
        end
        if (wr_mode) begin
          next_wait_mode = wbyte[WAIT_BIT];
          next_rc_osc_select = wbyte[RC_BIT];
          next_test_mode = wbyte[TEST_BIT] && !readout_lock;
          if (wbyte[STOP_BIT]) begin
            next_prog_latch_enable = 1'b0;
          end
          if (wbyte[BOOT_BIT]) begin
            next_state = ST_WIPE;
            next_wipe_ptr = 8'h00;
            next_prog_latch_enable = 1'b0;
          end
        end
        // commit at end of the operation: latch cleared with pump running
        if (!next_prog_latch_enable && prog_latch_enable && pump_enable) begin
          if (!protected_offs(lat_addr, upper_region_unlock)) begin
            store = 1'b1;
            // programming only pulls bits low; erase returns all ones
            store_val = erase_select ? ERASED : (arr.rdata & lat_data);
            if (lat_addr == OPTION_IDX[7:0] && !erase_select && !lat_data[PROT_BIT]) begin
              store_val[PROT_BIT] = 1'b0;
            end
          end
        end
      end
      default: next_state = ST_RUN;
    endcase
    // read mode forces erase select and pump off
    if (!next_prog_latch_enable) begin
      next_erase_select = 1'b0;
      next_pump_enable = 1'b0;
      next_addr_latched = 1'b0;
    end
  end

  // array port: read address follows the latched byte during commit
  assign arr.we = store;
  assign arr.waddr = state == ST_WIPE ? wipe_ptr : lat_addr;
  assign arr.wdata = store_val;
  // the reset edge itself fetches the option byte, so one reset edge is enough
  assign arr.raddr = (!RST_N || state == ST_LOAD) ? OPTION_IDX[7:0] :
                     (prog_latch_enable ? lat_addr : off);

  // bus answer: one wait state, data two cycles for array reads
  always_comb begin
    next_ack = 1'b0;
    next_rd_pending = rd_pending;
    next_rd_blank = rd_blank;
    next_rdata = rdata;
    if (rd_pending) begin
      next_rd_pending = 1'b0;
      next_ack = 1'b1;
      next_rdata = rd_blank ? {24'h0000_00, ERASED} : {24'h0000_00, arr.rdata};
    end else if (rd_arr) begin
      next_rd_pending = 1'b1;
      next_rd_blank = prog_latch_enable;
    end else if (req) begin
      next_ack = 1'b1;
      if (AVS_ADDRESS == CTRL_ADDR) begin
        next_rdata = {29'h0000_0000, erase_select, prog_latch_enable, pump_enable};
      end else if (AVS_ADDRESS == STAT_ADDR) begin
        next_rdata = {29'h0000_0000, addr_latched, readout_lock, upper_region_unlock};
      end else if (AVS_ADDRESS == MODE_ADDR) begin
        next_rdata = {27'h0000_000, 1'b0, test_mode, rc_osc_select, wait_mode, 1'b0};
      end else begin
        next_rdata = 32'h0000_0000;
      end
    end
  end

  // state registers; synchronous reset restarts the options load
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state <= ST_LOAD;
      prog_latch_enable <= CTRL_RESET[LAT_BIT];
      erase_select <= CTRL_RESET[ERA_BIT];
      pump_enable <= CTRL_RESET[PGM_BIT];
      addr_latched <= 1'b0;
      lat_addr <= 8'h00;
      lat_data <= 8'h00;
      upper_region_unlock <= 1'b0;
      readout_lock <= 1'b1;
      rc_osc_select <= 1'b0;
      wait_mode <= 1'b0;
      test_mode <= 1'b0;
      wipe_ptr <= 8'h00;
      ack <= 1'b0;
      rd_pending <= 1'b0;
      rdata <= 32'h0000_0000;
      rd_blank <= 1'b0;
    end else begin
      state <= next_state;
      prog_latch_enable <= next_prog_latch_enable;
      erase_select <= next_erase_select;
      pump_enable <= next_pump_enable;
      addr_latched <= next_addr_latched;
      lat_addr <= next_lat_addr;
      lat_data <= next_lat_data;
      upper_region_unlock <= next_upper_region_unlock;
      readout_lock <= next_readout_lock;
      rc_osc_select <= next_rc_osc_select;
      wait_mode <= next_wait_mode;
      test_mode <= next_test_mode;
      wipe_ptr <= next_wipe_ptr;
      ack <= next_ack;
      rd_pending <= next_rd_pending;
      rdata <= next_rdata;
      rd_blank <= next_rd_blank;
    end
  end

  // waitrequest drops for the one cycle the answer stands
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
  assign AVS_READDATA = rdata;
  assign PUMP_ON = pump_enable;
  assign PUMP_CLK_RC = rc_osc_select;
  assign TEST_MODE = test_mode;
  assign UPPER_UNLOCKED = upper_region_unlock;
  assign READOUT_LOCKED = readout_lock;
endmodule : eep_ctrl
`default_nettype wire

// [core/eep_pkg.sv]
// package: register map, field positions and timing for the byte-erase EEPROM controller
package eep_pkg;
  // control register (byte address = index * 4)
  localparam logic [9:0] CTRL_IDX = 10'h007;
  localparam logic [11:0] CTRL_ADDR = 12'h001C;
  // array window: index 0x100..0x1FF, byte address = index * 4
  localparam logic [9:0] ARRAY_IDX = 10'h100;
  localparam logic [9:0] OPTION_IDX = 10'h100;
  // status register of our own: latched option values and address latched flag
  localparam logic [11:0] STAT_ADDR = 12'h0020;
  // mode register of our own: stop, wait, rc select, test, bootstrap requests
  localparam logic [11:0] MODE_ADDR = 12'h0024;
  // control register field positions
  localparam int PGM_BIT = 0;
  localparam int LAT_BIT = 1;
  localparam int ERA_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // option byte field positions
  localparam int SEC_BIT = 0;
  localparam int PROT_BIT = 1;
  // mode register field positions
  localparam int STOP_BIT = 0;
  localparam int WAIT_BIT = 1;
  localparam int RC_BIT = 2;
  localparam int TEST_BIT = 3;
  localparam int BOOT_BIT = 4;
  // array data codes
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] PROGRAMMED = 8'h00;
  // first protected offset: lower 32 bytes always writable
  localparam logic [7:0] UNPROT_LIMIT = 8'h20;
  // options loader length: one cycle, only the option byte is read
  localparam int LOAD_CYCLES = 1;
  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_RUN = 3'b010,
    ST_WIPE = 3'b100
  } eep_state_t;
endpackage : eep_pkg
